// file: core/dsc_engine.sv
// How it works
// - 64-bit blocks, 56-bit key, both directions
// - Initial permutation, split halves, sixteen rounds
// - Expand right half, mix key, substitute
// - Permute substitution, XOR into left half
// - New value to right, old right to left
// - Round key from shifted, permuted key
// - Rejoin halves, apply inverse initial permutation
// - Direction level selects encrypt or decrypt
// - Rising start edge begins operation on inputs
// - Key parity bits are ignored
// - Completion flag sixteen cycles after start
// - No idle cycles between operations
`timescale 1ns/1ps
module dsc_engine
    import dsc_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_b_i,
    input  wire logic                   enc_i,
    input  wire logic                   go_i,
    input  wire logic [DES_BLOCK_W-1:0] data_i,
    input  wire logic [DES_BLOCK_W-1:0] key_i,
    output logic      [DES_BLOCK_W-1:0] data_o,
    output logic                        ready_o
);

    logic                   go_q_r;
    logic                   busy_r;
    logic [DES_CNT_W-1:0]   cnt_r;
    logic                   enc_r;
    logic [DES_HALF_W-1:0]  left_r;
    logic [DES_HALF_W-1:0]  right_r;
    logic [DES_CD_W-1:0]    cd_r;
    logic [DES_CD_W-1:0]    cd0_r;
    logic [DES_BLOCK_W-1:0] data_r;
    logic                   ready_r;

    logic                   start_w;
    logic                   last_w;
    logic [DES_BLOCK_W-1:0] ip_w;
    logic [DES_CD_W-1:0]    pc1_w;
    logic [DES_CD_W-1:0]    cd_load_w;
    logic [DES_CD_W-1:0]    cd_next_w;
    logic                   two_w;
    logic [DES_RK_W-1:0]    rk_w;
    logic [DES_HALF_W-1:0]  f_w;
    logic [DES_HALF_W-1:0]  new_r_w;
    logic [DES_BLOCK_W-1:0] pre_w;
    logic [DES_BLOCK_W-1:0] fp_w;

    // Rotates both 28-bit key halves one or two places
    function automatic logic [DES_CD_W-1:0] rot_cd(
        input logic [DES_CD_W-1:0] cd,
        input logic                left,
        input logic                two
    );
        logic [27:0] c;
        logic [27:0] d;
        c = cd[55:28];
        d = cd[27:0];
        if (left)
        begin
            c = two ? {c[25:0], c[27:26]} : {c[26:0], c[27]};
            d = two ? {d[25:0], d[27:26]} : {d[26:0], d[27]};
        end
        else
        begin
            c = two ? {c[1:0], c[27:2]} : {c[0], c[27:1]};
            d = two ? {d[1:0], d[27:2]} : {d[0], d[27:1]};
        end
        return {c, d};
    endfunction : rot_cd

    ////////////////////////////////////////////////////////////////////////
    // Start detection and round sequencing
    assign start_w = go_i & ~go_q_r;
    assign last_w  = busy_r & (cnt_r == DES_LAST_ROUND);

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            go_q_r <= 1'b0;
            busy_r <= 1'b0;
            cnt_r  <= DES_FIRST_ROUND;
            enc_r  <= 1'b0;
        end
        else
        begin
            go_q_r <= go_i;
            // A start on the final round edge chains with no gap
            busy_r <= start_w | (busy_r & ~last_w);
            cnt_r  <= start_w ? DES_FIRST_ROUND
                    : busy_r ? cnt_r + DES_ROUND_STEP : cnt_r;
            if (start_w)
                enc_r <= enc_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input permutations
    for (genvar k = 0; k < DES_BLOCK_W; k++)
    begin : g_ip
        assign ip_w[DES_BLOCK_W-1-k] =
            data_i[DES_BLOCK_W-dsc_ip_pos(k)];
    end

    // Parity bits 8, 16, ... 64 never reach the key schedule
    for (genvar k = 0; k < DES_CD_W; k++)
    begin : g_pc1
        assign pc1_w[DES_CD_W-1-k] =
            key_i[DES_BLOCK_W-DES_PC1_TAB[k]];
    end

    ////////////////////////////////////////////////////////////////////////
    // Key schedule: encrypt rotates left, decrypt walks back right
    assign cd_load_w = enc_i ? rot_cd(pc1_w, 1'b1, 1'b0) : pc1_w;
    assign two_w     = enc_r
                     ? ~DES_SHIFT_ONE[cnt_r + DES_ROUND_STEP]
                     : ~DES_SHIFT_ONE[DES_LAST_ROUND - cnt_r];
    assign cd_next_w = rot_cd(cd_r, enc_r, two_w);

    for (genvar k = 0; k < DES_RK_W; k++)
    begin : g_pc2
        assign rk_w[DES_RK_W-1-k] = cd_r[DES_CD_W-DES_PC2_TAB[k]];
    end

    ////////////////////////////////////////////////////////////////////////
    // Round datapath
    dsc_round_f u_round_f (
        .half_i (right_r),
        .rkey_i (rk_w),
        .f_o    (f_w)
    );

    assign new_r_w = left_r ^ f_w;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            left_r  <= '0;
            right_r <= '0;
            cd_r    <= '0;
            cd0_r   <= '0;
        end
        else if (start_w)
        begin
            left_r  <= ip_w[DES_BLOCK_W-1:DES_HALF_W];
            right_r <= ip_w[DES_HALF_W-1:0];
            cd_r    <= cd_load_w;
            cd0_r   <= pc1_w;
        end
        else if (busy_r)
        begin
            left_r  <= right_r;
            right_r <= new_r_w;
            cd_r    <= cd_next_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Final swap and inverse permutation
    assign pre_w = {new_r_w, right_r};

    for (genvar k = 0; k < DES_BLOCK_W; k++)
    begin : g_fp
        assign fp_w[DES_BLOCK_W-dsc_ip_pos(k)] =
            pre_w[DES_BLOCK_W-1-k];
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            data_r  <= '0;
            ready_r <= 1'b0;
        end
        else
        begin
            ready_r <= last_w;
            if (last_w)
                data_r <= fp_w;
        end
    end

    assign data_o  = data_r;
    assign ready_o = ready_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_quiet16;
        (!start_w) [*8] ##1 (!start_w) [*8];
    endsequence

    sequence s_round_step;
        busy_r && !start_w;
    endsequence

    chk_ready_latency: assert property (
        start_w ##1 s_quiet16 |=> ready_o)
        else $error("completion not 16 cycles after start");

    chk_ready_cause: assert property (
        ready_o |-> $past(busy_r) && $past(cnt_r) == DES_LAST_ROUND)
        else $error("completion without final round");

    chk_load_halves: assert property (
        start_w |=> {left_r, right_r} == $past(ip_w) && busy_r
                    && cnt_r == DES_FIRST_ROUND)
        else $error("halves not loaded from permuted input");

    chk_half_swap: assert property (
        s_round_step |=> left_r == $past(right_r))
        else $error("left half did not take old right half");

    chk_round_value: assert property (
        s_round_step |=> right_r == $past(left_r ^ f_w))
        else $error("right half not left xor round function");

    chk_key_wrap: assert property (
        last_w |-> cd_r == (enc_r ? cd0_r : rot_cd(cd0_r, 1'b1, 1'b0)))
        else $error("key schedule rotation total wrong");

    chk_dir_latch: assert property (
        start_w |=> enc_r == $past(enc_i))
        else $error("direction not taken at start");

    chk_out_perm: assert property (
        ready_o |-> data_o == $past(fp_w))
        else $error("result not inverse permutation of halves");

    chk_out_hold: assert property (
        !ready_o |-> $stable(data_o))
        else $error("result changed without completion");

    chk_chain_start: assert property (
        last_w && start_w |=> busy_r && cnt_r == DES_FIRST_ROUND ##16 ready_o)
        else $error("back to back start lost a cycle");

endmodule : dsc_engine

// file: include/dsc_pkg.sv
package dsc_pkg;

    localparam int DES_BLOCK_W = 64;
    localparam int DES_HALF_W  = 32;
    localparam int DES_CD_W    = 56;
    localparam int DES_RK_W    = 48;
    localparam int DES_CNT_W   = 4;
    localparam int DES_SBOX_N  = 8;

    localparam logic [DES_CNT_W-1:0] DES_FIRST_ROUND = 4'h0;
    localparam logic [DES_CNT_W-1:0] DES_LAST_ROUND  = 4'hF;
    localparam logic [DES_CNT_W-1:0] DES_ROUND_STEP  = 4'h1;

    // Rounds whose key halves rotate by one place, round 1 in bit 0
    localparam logic [15:0] DES_SHIFT_ONE = 16'h8103;

    localparam int DES_P_TAB [32] = '{
        16, 7, 20, 21, 29, 12, 28, 17, 1, 15, 23, 26, 5, 18, 31, 10,
        2, 8, 24, 14, 32, 27, 3, 9, 19, 13, 30, 6, 22, 11, 4, 25};

    localparam int DES_PC1_TAB [56] = '{
        57, 49, 41, 33, 25, 17, 9, 1, 58, 50, 42, 34, 26, 18,
        10, 2, 59, 51, 43, 35, 27, 19, 11, 3, 60, 52, 44, 36,
        63, 55, 47, 39, 31, 23, 15, 7, 62, 54, 46, 38, 30, 22,
        14, 6, 61, 53, 45, 37, 29, 21, 13, 5, 28, 20, 12, 4};

    localparam int DES_PC2_TAB [48] = '{
        14, 17, 11, 24, 1, 5, 3, 28, 15, 6, 21, 10,
        23, 19, 12, 4, 26, 8, 16, 7, 27, 20, 13, 2,
        41, 52, 31, 37, 47, 55, 30, 40, 51, 45, 33, 48,
        44, 49, 39, 56, 34, 53, 46, 42, 50, 36, 29, 32};

    // Entry {row, col} sits in nibble 63 - index, entry 0 leftmost
    localparam logic [255:0] DES_SBOX [DES_SBOX_N] = '{
        {128'hE4D1_2FB8_3A6C_5907_0F74_E2D1_A6CB_9538,
         128'h41E8_D62B_FC97_3A50_FC82_4917_5B3E_A06D},
        {128'hF18E_6B34_972D_C05A_3D47_F28E_C01A_69B5,
         128'h0E7B_A4D1_58C6_932F_D8A1_3F42_B67C_05E9},
        {128'hA09E_63F5_1DC7_B428_D709_346A_285E_CBF1,
         128'hD649_8F30_B12C_5AE7_1AD0_6987_4FE3_B52C},
        {128'h7DE3_069A_1285_BC4F_D8B5_6F03_472C_1AE9,
         128'hA690_CB7D_F13E_5284_3F06_A1D8_945B_C72E},
        {128'h2C41_7AB6_853F_D0E9_EB2C_47D1_50FA_3986,
         128'h421B_AD78_F9C5_630E_B8C7_1E2D_6F09_A453},
        {128'hC1AF_9268_0D34_E75B_AF42_7C95_61DE_0B38,
         128'h9EF5_28C3_704A_1BD6_432C_95FA_BE17_608D},
        {128'h4B2E_F08D_3C97_5A61_D0B7_491A_E35C_2F86,
         128'h14BD_C37E_AF68_0592_6BD8_14A7_950F_E23C},
        {128'hD284_6FB1_A93E_50C7_1FD8_A374_C56B_0E92,
         128'h7B41_9CE2_06AD_F358_21E7_4A8D_FC90_356B}};

    // Source bit (1 = leftmost) of initial permutation output k
    function automatic int dsc_ip_pos(input int k);
        int row;
        row = k / 8;
        return ((row < 4) ? (58 + 2 * row) : (57 + 2 * (row - 4)))
               - 8 * (k % 8);
    endfunction : dsc_ip_pos

    // Source bit (1 = leftmost) of expansion output k
    function automatic int dsc_e_pos(input int k);
        return ((4 * (k / 6) + (k % 6) + 31) % 32) + 1;
    endfunction : dsc_e_pos

endpackage : dsc_pkg

// file: core/dsc_round_f.sv
`timescale 1ns/1ps
module dsc_round_f
    import dsc_pkg::*;
(
    input  wire logic [DES_HALF_W-1:0] half_i,
    input  wire logic [DES_RK_W-1:0]   rkey_i,
    output logic      [DES_HALF_W-1:0] f_o
);

    logic [DES_RK_W-1:0]   exp_w;
    logic [DES_RK_W-1:0]   mix_w;
    logic [DES_HALF_W-1:0] sub_w;

    ////////////////////////////////////////////////////////////////////////
    // Expansion, key mixing, substitution
    for (genvar k = 0; k < DES_RK_W; k++)
    begin : g_exp
        assign exp_w[DES_RK_W-1-k] =
            half_i[DES_HALF_W-dsc_e_pos(k)];
    end

    assign mix_w = exp_w ^ rkey_i;

    for (genvar b = 0; b < DES_SBOX_N; b++)
    begin : g_sbox
        logic [5:0] six_w;
        logic [5:0] idx_w;
        assign six_w = mix_w[DES_RK_W-1-6*b -: 6];
        assign idx_w = {six_w[5], six_w[0], six_w[4:1]};
        assign sub_w[DES_HALF_W-1-4*b -: 4] =
            DES_SBOX[b][255-4*idx_w -: 4];
    end

    ////////////////////////////////////////////////////////////////////////
    // Permutation of the substitution result
    for (genvar k = 0; k < DES_HALF_W; k++)
    begin : g_perm
        assign f_o[DES_HALF_W-1-k] =
            sub_w[DES_HALF_W-DES_P_TAB[k]];
    end

endmodule : dsc_round_f

// file: sim/dsc_host_model.sv
`timescale 1ns/1ps
module dsc_host_model
    import dsc_pkg::*;
(
    input  wire logic                   clk_i,
    output logic                        go_o,
    output logic                        enc_o,
    output logic      [DES_BLOCK_W-1:0] data_o,
    output logic      [DES_BLOCK_W-1:0] key_o
);

    initial
    begin
        go_o   = 1'b0;
        enc_o  = 1'b1;
        data_o = 64'h0000_0000_0000_0000;
        key_o  = 64'h0000_0000_0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // One start pulse; inputs scrambled once captured
    task automatic start(input logic                   enc,
                         input logic [DES_BLOCK_W-1:0] blk,
                         input logic [DES_BLOCK_W-1:0] key);
        start_held(enc, blk, key);
        go_o = 1'b0;
    endtask : start

    // Raises go and leaves it high; inputs scrambled once captured
    task automatic start_held(input logic                   enc,
                              input logic [DES_BLOCK_W-1:0] blk,
                              input logic [DES_BLOCK_W-1:0] key);
        @(posedge clk_i);
        #1;
        go_o   = 1'b1;
        enc_o  = enc;
        data_o = blk;
        key_o  = key;
        @(posedge clk_i);
        #1;
        enc_o  = ~enc;
        data_o = ~blk;
        key_o  = ~key;
    endtask : start_held

    task automatic drop_go();
        @(posedge clk_i);
        #1;
        go_o = 1'b0;
    endtask : drop_go

endmodule : dsc_host_model

// file: sim/tb.sv
`timescale 1ns/1ps
module tb
    import dsc_pkg::*;
;
    localparam logic [63:0] KEY_A = 64'h1334_5779_9BBC_DFF1;
    localparam logic [63:0] PT_A  = 64'h0123_4567_89AB_CDEF;
    localparam logic [63:0] CT_A  = 64'h85E8_1354_0F0A_B405;
    localparam logic [63:0] CT_Z  = 64'h8CA6_4DE9_C1B1_23A7;
    localparam logic [63:0] PAR   = 64'h0101_0101_0101_0101;
    localparam logic [63:0] ZERO  = 64'h0000_0000_0000_0000;
    localparam logic [63:0] ONE   = 64'h0000_0000_0000_0001;
    localparam logic [63:0] LAT   = 64'h0000_0000_0000_0010;

    logic                   clk_i;
    logic                   rst_b_i;
    logic                   go;
    logic                   enc;
    logic [DES_BLOCK_W-1:0] din;
    logic [DES_BLOCK_W-1:0] key;
    logic [DES_BLOCK_W-1:0] dout;
    logic                   ready;
    int                     num_errors;
    int                     n_tests;
    int                     n;

    dsc_host_model u_host (.clk_i(clk_i), .go_o(go), .enc_o(enc),
                           .data_o(din), .key_o(key));

    dsc_engine uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .enc_i(enc),
                    .go_i(go), .data_i(din), .key_i(key),
                    .data_o(dout), .ready_o(ready));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Edges from capture until the completion pulse shows
    task automatic wait_done();
        for (n = 1; n <= 40; n++)
        begin
            @(posedge clk_i);
            #1;
            if (ready === 1'b1)
                return;
        end
        num_errors++;
        $display("Error ready_o expected 1 seen timeout");
        test_done();
    endtask : wait_done

    task automatic run_op(input logic enc_v, input logic [63:0] blk,
                          input logic [63:0] k, input logic [63:0] exp);
        u_host.start(enc_v, blk, k);
        wait_done();
        check("latency", 64'(n), LAT);
        check("data_o", dout, exp);
        @(posedge clk_i);
        #1;
        check("ready_o low", 64'(ready), ZERO);
        check("data_o held", dout, exp);
    endtask : run_op

    ////////////////////////////////////////////////////////////////////////
    task automatic sc_vectors();
        run_op(1'b1, PT_A, KEY_A, CT_A);
        run_op(1'b0, CT_A, KEY_A, PT_A);
        run_op(1'b1, PT_A, KEY_A ^ PAR, CT_A);
        run_op(1'b1, ZERO, PAR, CT_Z);
        run_op(1'b1, ~ZERO, ~ZERO, ~CT_Z);
        run_op(1'b0, ~CT_Z, ~ZERO, ~ZERO);
    endtask : sc_vectors

    // Second start lands on the final round edge of the first
    task automatic sc_back_to_back();
        u_host.start(1'b1, PT_A, KEY_A);
        repeat (14) @(posedge clk_i);
        u_host.start(1'b0, CT_Z, ZERO);
        check("ready_o first", 64'(ready), ONE);
        check("data_o first", dout, CT_A);
        wait_done();
        check("latency second", 64'(n), LAT);
        check("data_o second", dout, ZERO);
    endtask : sc_back_to_back

    // Restart mid-operation drops the first result
    task automatic sc_abort();
        u_host.start(1'b1, PT_A, KEY_A);
        repeat (4) @(posedge clk_i);
        u_host.start(1'b1, ZERO, ZERO);
        wait_done();
        check("latency restart", 64'(n), LAT);
        check("data_o restart", dout, CT_Z);
    endtask : sc_abort

    // Go held high past completion starts only once
    task automatic sc_held_go();
        u_host.start_held(1'b1, PT_A, KEY_A);
        wait_done();
        check("latency held go", 64'(n), LAT);
        check("data_o held go", dout, CT_A);
        n = 0;
        repeat (20)
        begin
            @(posedge clk_i);
            #1;
            n += int'(ready === 1'b1);
        end
        u_host.drop_go();
        check("ready_o while go high", 64'(n), ZERO);
    endtask : sc_held_go

    task automatic sc_reset();
        u_host.start(1'b1, PT_A, KEY_A);
        repeat (3) @(posedge clk_i);
        #1;
        rst_b_i = 1'b0;
        #1;
        check("data_o in reset", dout, ZERO);
        check("ready_o in reset", 64'(ready), ZERO);
        @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        n = 0;
        repeat (25)
        begin
            @(posedge clk_i);
            #1;
            n += int'(ready === 1'b1);
        end
        check("ready_o after reset", 64'(n), ZERO);
    endtask : sc_reset

    initial
    begin
        num_errors = 0;
        n_tests    = 0;
        rst_b_i    = 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        sc_vectors();
        sc_back_to_back();
        sc_abort();
        sc_held_go();
        sc_reset();
        run_op(1'b1, PT_A, KEY_A, CT_A);
        test_done();
    end

endmodule : tb
